// [core/mrss_regs.svh]
// constants for the rotate, subtract and skip datapath
`ifndef MRSS_REGS_SVH
`define MRSS_REGS_SVH
// ==========================================
// reset values and the set-byte fill value
`define MRSS_WORK_RST    8'h00
`define MRSS_FLAGS_RST   4'h0
`define MRSS_ALL_ONES    8'hFF
// ==========================================
// flag field positions
`define MRSS_FLAG_BORROW 0
`define MRSS_FLAG_NIBBLE 1
`define MRSS_FLAG_NULL   2
`define MRSS_FLAG_WRAP   3
// ==========================================
// cycle counts
`define MRSS_SKIP_CYCLES 2
`endif

// [core/mrss_pkg.sv]
// types for the rotate, subtract and skip datapath
package mrss_pkg;
  // ==========================================
  // operations
  typedef enum logic [3:0] {
    MRSS_OP_NONE        = 4'h0,
    MRSS_OP_ROT_WORK    = 4'h1,
    MRSS_OP_SBB_WORK    = 4'h2,
    MRSS_OP_SBB_MEM     = 4'h3,
    MRSS_OP_SUB_WORK    = 4'h4,
    MRSS_OP_SUB_MEM     = 4'h5,
    MRSS_OP_SUB_IMM     = 4'h6,
    MRSS_OP_DEC_SKIP    = 4'h7,
    MRSS_OP_DEC_WORK    = 4'h8,
    MRSS_OP_INC_SKIP    = 4'h9,
    MRSS_OP_INC_WORK    = 4'hA,
    MRSS_OP_BIT_SKIP    = 4'hB,
    MRSS_OP_SET_BYTE    = 4'hC,
    MRSS_OP_SET_BIT     = 4'hD,
    MRSS_OP_SWAP        = 4'hE,
    MRSS_OP_SWAP_WORK   = 4'hF
  } mrss_op_t;
  typedef enum logic [0:0] {
    MRSS_ST_RUN   = 1'b0,
    MRSS_ST_DUMMY = 1'b1
  } mrss_state_t;
  // ==========================================
  // carriers
  typedef struct packed {
    logic     valid;
    mrss_op_t op;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } mrss_req_t;
  typedef struct packed {
    logic signed_wrap_flag;
    logic result_null_flag;
    logic nibble_borrow_flag;
    logic borrow_flag;
  } mrss_flags_t;
  typedef struct packed {
    logic [7:0] sum;
    logic       c3;
    logic       c7;
    logic       wrap;
  } mrss_add_t;
endpackage : mrss_pkg

// [core/mrss_sub_adder.sv]
// complement-plus-carry adder used by every subtract form
`timescale 1ns/10ps
module mrss_sub_adder (
  input  wire logic [7:0]        work,
  input  wire logic [7:0]        operand,
  input  wire logic              carry_in,
  output mrss_pkg::mrss_add_t    result
);
  import mrss_pkg::*;
  logic [4:0] low;
  logic [4:0] high;
  logic [7:0] inv;
  always_comb begin
    inv         = ~operand;
    low         = {1'b0, work[3:0]} + {1'b0, inv[3:0]} + {4'h0, carry_in};
    high        = {1'b0, work[7:4]} + {1'b0, inv[7:4]} + {4'h0, low[4]};
    result.sum  = {high[3:0], low[3:0]};
    result.c3   = low[4];
    result.c7   = high[4];
    // overflow when both inputs agree in sign and the sum does not
    result.wrap = (work[7] == inv[7]) && (high[3] != work[7]);
  end
endmodule : mrss_sub_adder

// [core/mrss_skip_seq.sv]
// dummy-cycle sequencer that retires a discarded prefetch
`timescale 1ns/10ps
module mrss_skip_seq (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic skip_take,
  output logic      busy,
  output logic      flush
);
  import mrss_pkg::*;
  typedef struct packed {
    mrss_state_t state;
    logic        flush;
  } mrss_seq_state_t;
  mrss_seq_state_t r;
  mrss_seq_state_t next_r;
  always_comb begin
    next_r       = r;
    next_r.flush = 1'b0;
    case (r.state)
      MRSS_ST_RUN: begin
        if (skip_take) begin
          next_r.state = MRSS_ST_DUMMY;
          next_r.flush = 1'b1;
        end
      end
      MRSS_ST_DUMMY: begin
        next_r.state = MRSS_ST_RUN;
      end
      default: begin
        next_r.state = MRSS_ST_RUN;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{state: MRSS_ST_RUN, flush: 1'b0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end
  assign busy  = (r.state == MRSS_ST_DUMMY);
  assign flush = r.flush;
endmodule : mrss_skip_seq

// [core/mrss_core.sv]
// datapath for rotate, subtract, skip, set and swap operations
`timescale 1ns/10ps
`include "mrss_regs.svh"
module mrss_core (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  input  wire mrss_pkg::mrss_req_t req,
  output logic [7:0]             work,
  output mrss_pkg::mrss_flags_t  flags,
  output logic [7:0]             mem_wdata,
  output logic                   mem_we,
  output logic                   skip_taken,
  output logic                   prefetch_flush,
  output logic                   busy
);
  import mrss_pkg::*;
  // ==========================================
  // state
  typedef struct packed {
    logic [7:0]  work;
    mrss_flags_t flags;
    logic [7:0]  mem_wdata;
    logic        mem_we;
    logic        skip_taken;
  } mrss_core_state_t;
  mrss_core_state_t r;
  mrss_core_state_t next_r;
  mrss_add_t        add_res;
  logic [7:0]       add_opnd;
  logic             add_cin;
  logic             seq_busy;
  logic             seq_flush;
  logic             take;
  logic [7:0]       dec_val;
  logic [7:0]       inc_val;
  logic [7:0]       bit_mask;
  logic             accept;
  // ==========================================
  // shared adder
  always_comb begin
    add_opnd = req.mem;
    add_cin  = 1'b1;
    if (req.op == MRSS_OP_SUB_IMM) begin
      add_opnd = req.imm;
    end
    if (req.op == MRSS_OP_SBB_WORK || req.op == MRSS_OP_SBB_MEM) begin
      add_cin = r.flags.borrow_flag;
    end
  end
  mrss_sub_adder u_adder (
    .work     (r.work),
    .operand  (add_opnd),
    .carry_in (add_cin),
    .result   (add_res)
  );
  // ==========================================
  // operation decode
  // requests during the dummy cycle are ignored: that slot is the discard
  assign accept   = req.valid && !seq_busy;
  assign dec_val  = req.mem - 8'h01;
  assign inc_val  = req.mem + 8'h01;
  assign bit_mask = 8'h01 << req.bit_sel;
  always_comb begin
    next_r            = r;
    next_r.mem_we     = 1'b0;
    next_r.skip_taken = 1'b0;
    take              = 1'b0;
    if (accept) begin
      case (req.op)
        MRSS_OP_ROT_WORK: begin
          next_r.work = {r.flags.borrow_flag, req.mem[7:1]};
          next_r.flags.borrow_flag = req.mem[0];
        end
        MRSS_OP_SBB_WORK, MRSS_OP_SUB_WORK, MRSS_OP_SUB_IMM: begin
          next_r.work = add_res.sum;
          next_r.flags.borrow_flag        = add_res.c7;
          next_r.flags.nibble_borrow_flag = add_res.c3;
          next_r.flags.result_null_flag   = (add_res.sum == 8'h00);
          next_r.flags.signed_wrap_flag   = add_res.wrap;
        end
        MRSS_OP_SBB_MEM, MRSS_OP_SUB_MEM: begin
          next_r.mem_wdata = add_res.sum;
          next_r.mem_we    = 1'b1;
          next_r.flags.borrow_flag        = add_res.c7;
          next_r.flags.nibble_borrow_flag = add_res.c3;
          next_r.flags.result_null_flag   = (add_res.sum == 8'h00);
          next_r.flags.signed_wrap_flag   = add_res.wrap;
        end
        MRSS_OP_DEC_SKIP: begin
          next_r.mem_wdata = dec_val;
          next_r.mem_we    = 1'b1;
          take             = (dec_val == 8'h00);
        end
        MRSS_OP_INC_SKIP: begin
          next_r.mem_wdata = inc_val;
          next_r.mem_we    = 1'b1;
          take             = (inc_val == 8'h00);
        end
        MRSS_OP_DEC_WORK: begin
          next_r.work = dec_val;
          take        = (dec_val == 8'h00);
        end
        MRSS_OP_INC_WORK: begin
          next_r.work = inc_val;
          take        = (inc_val == 8'h00);
        end
        MRSS_OP_BIT_SKIP: begin
          take = req.mem[req.bit_sel];
        end
        MRSS_OP_SET_BYTE: begin
          next_r.mem_wdata = `MRSS_ALL_ONES;
          next_r.mem_we    = 1'b1;
        end
        MRSS_OP_SET_BIT: begin
          next_r.mem_wdata = req.mem | bit_mask;
          next_r.mem_we    = 1'b1;
        end
        MRSS_OP_SWAP: begin
          next_r.mem_wdata = {req.mem[3:0], req.mem[7:4]};
          next_r.mem_we    = 1'b1;
        end
        MRSS_OP_SWAP_WORK: begin
          next_r.work = {req.mem[3:0], req.mem[7:4]};
        end
        default: begin
          next_r.mem_we = 1'b0;
        end
      endcase
    end
    next_r.skip_taken = take;
  end
  // ==========================================
  // dummy cycle sequencer
  mrss_skip_seq u_seq (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .skip_take (take),
    .busy      (seq_busy),
    .flush     (seq_flush)
  );
  // ==========================================
  // registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{work: `MRSS_WORK_RST, flags: `MRSS_FLAGS_RST,
             mem_wdata: 8'h00, mem_we: 1'b0, skip_taken: 1'b0};
    end else if (clk_en) begin
      r <= next_r;
    end
  end
  assign work           = r.work;
  assign flags          = r.flags;
  assign mem_wdata      = r.mem_wdata;
  assign mem_we         = r.mem_we;
  assign skip_taken     = r.skip_taken;
  assign prefetch_flush = seq_flush;
  assign busy           = seq_busy;
endmodule : mrss_core

// [bench/mrss_core_assertions.sv]
// checker for the rotate, subtract and skip datapath
`timescale 1ns/10ps
module mrss_core_assertions (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire mrss_pkg::mrss_req_t   req,
  input wire logic [7:0]            work,
  input wire mrss_pkg::mrss_flags_t flags,
  input wire logic [7:0]            mem_wdata,
  input wire logic                  mem_we,
  input wire logic                  skip_taken,
  input wire logic                  prefetch_flush,
  input wire logic                  busy
);
  import mrss_pkg::*;
  // ==========================================
  // helpers
  logic take;
  logic sel;
  assign take = clk_en && req.valid && !busy;
  assign sel  = req.mem[req.bit_sel];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // properties
  flush_pair_a: assert property (skip_taken == prefetch_flush)
    else $error("flush and skip differ");
  dummy_len_a: assert property (busy && clk_en |=> !busy)
    else $error("dummy cycle too long");
  // a refused slot must not leak a write
  no_stray_a: assert property (clk_en && !take |=> !mem_we)
    else $error("write without accepted op");
  rot_work_a: assert property (take && req.op == MRSS_OP_ROT_WORK |=>
    work == {$past(flags.borrow_flag), $past(req.mem[7:1])} && !mem_we
    && flags == {$past(flags[3:1]), $past(req.mem[0])})
    else $error("bad rotate");
  sub_work_a: assert property (take && req.op == MRSS_OP_SUB_WORK |=>
    work == $past(work) - $past(req.mem) && !mem_we)
    else $error("bad subtract");
  inc_skip_a: assert property (take && req.op == MRSS_OP_INC_SKIP |=>
    mem_we && mem_wdata == $past(req.mem) + 8'h01
    && skip_taken == (mem_wdata == 8'h00) && $stable(flags))
    else $error("bad increment skip");
  bit_skip_a: assert property (take && req.op == MRSS_OP_BIT_SKIP |=>
    skip_taken == $past(sel) && $stable(flags))
    else $error("bad bit test");
  set_byte_a: assert property (take && req.op == MRSS_OP_SET_BYTE |=>
    mem_we && mem_wdata == 8'hFF && $stable(flags))
    else $error("bad set byte");
  swap_work_a: assert property (take && req.op == MRSS_OP_SWAP_WORK |=>
    work == {$past(req.mem[3:0]), $past(req.mem[7:4])} && !mem_we
    && $stable(flags))
    else $error("bad swap to work");
  sbb_work_a: assert property (take && req.op == MRSS_OP_SBB_WORK |=>
    work == $past(work) + ~$past(req.mem) + $past(flags.borrow_flag)
    && !mem_we)
    else $error("bad subtract with borrow");
endmodule : mrss_core_assertions

bind mrss_core mrss_core_assertions u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
  .work(work), .flags(flags), .mem_wdata(mem_wdata), .mem_we(mem_we),
  .skip_taken(skip_taken), .prefetch_flush(prefetch_flush), .busy(busy)
);

// [bench/testbench.sv]
// self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/10ps
module testbench;
  import mrss_pkg::*;
  typedef struct {
    mrss_op_t   op;
    logic [7:0] d;
    logic [2:0] bs;
    logic [7:0] ew;
    logic [3:0] ef;
    logic       we;
    logic [7:0] wd;
    logic       sk;
  } mrss_row_t;
  logic        core_clk;
  logic        rst_n;
  logic        clk_en;
  mrss_req_t   req;
  logic [7:0]  work;
  mrss_flags_t flags;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        skip_taken;
  logic        prefetch_flush;
  logic        busy;
  int          errors;
  int          compares;
  mrss_row_t   r;
  // ==========================================
  // rows run in order; work and flags carry over
  mrss_row_t rows [18] = '{
    '{MRSS_OP_SUB_IMM,  8'h01,3'h0,8'hFF,4'h0,1'h0,8'h00,1'h0},
    '{MRSS_OP_ROT_WORK, 8'h03,3'h0,8'h01,4'h1,1'h0,8'h00,1'h0},
    '{MRSS_OP_SBB_WORK, 8'h01,3'h0,8'h00,4'h7,1'h0,8'h00,1'h0},
    '{MRSS_OP_SBB_MEM,  8'h10,3'h0,8'h00,4'h2,1'h1,8'hF0,1'h0},
    '{MRSS_OP_SUB_IMM,  8'h80,3'h0,8'h80,4'hA,1'h0,8'h00,1'h0},
    '{MRSS_OP_SUB_WORK, 8'h01,3'h0,8'h7F,4'h9,1'h0,8'h00,1'h0},
    '{MRSS_OP_SUB_MEM,  8'h7F,3'h0,8'h7F,4'h7,1'h1,8'h00,1'h0},
    '{MRSS_OP_DEC_SKIP, 8'h01,3'h0,8'h7F,4'h7,1'h1,8'h00,1'h1},
    '{MRSS_OP_DEC_WORK, 8'h05,3'h0,8'h04,4'h7,1'h0,8'h00,1'h0},
    '{MRSS_OP_INC_WORK, 8'hFF,3'h0,8'h00,4'h7,1'h0,8'h00,1'h1},
    '{MRSS_OP_INC_SKIP, 8'hFF,3'h0,8'h00,4'h7,1'h1,8'h00,1'h1},
    '{MRSS_OP_BIT_SKIP, 8'h80,3'h7,8'h00,4'h7,1'h0,8'h00,1'h1},
    '{MRSS_OP_BIT_SKIP, 8'h7F,3'h7,8'h00,4'h7,1'h0,8'h00,1'h0},
    '{MRSS_OP_SET_BYTE, 8'h12,3'h0,8'h00,4'h7,1'h1,8'hFF,1'h0},
    '{MRSS_OP_SET_BIT,  8'h00,3'h5,8'h00,4'h7,1'h1,8'h20,1'h0},
    '{MRSS_OP_SWAP,     8'hA5,3'h0,8'h00,4'h7,1'h1,8'h5A,1'h0},
    '{MRSS_OP_SWAP_WORK,8'h3C,3'h0,8'hC3,4'h7,1'h0,8'h00,1'h0},
    '{MRSS_OP_NONE,     8'h00,3'h0,8'hC3,4'h7,1'h0,8'h00,1'h0}};

  mrss_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .work(work), .flags(flags), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .skip_taken(skip_taken), .prefetch_flush(prefetch_flush), .busy(busy));

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  // run needs about 50 cycles; generous margin
  initial begin
    #(25 * 400);
    errors++;
    wrap_up();
  end

  initial begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    req = '0;
    repeat (20) @(negedge core_clk);
    chk("rst work", work, 8'h00);
    chk("rst flags", {4'h0, flags}, 8'h00);
    chk("rst out", {5'h00, mem_we, skip_taken, busy}, 8'h00);
    chk("rst flush", {mem_wdata[6:0], prefetch_flush}, 8'h00);
    rst_n = 1'h1;
    @(negedge core_clk);
    foreach (rows[i]) begin
      r = rows[i];
      req.valid = 1'h1;
      req.op = r.op;
      req.bit_sel = r.bs;
      // literal and memory differ so a swapped operand shows up
      req.mem = (r.op == MRSS_OP_SUB_IMM) ? ~r.d : r.d;
      req.imm = (r.op == MRSS_OP_SUB_IMM) ? r.d : ~r.d;
      @(negedge core_clk);
      chk("work", work, r.ew);
      chk("flags", {4'h0, flags}, {4'h0, r.ef});
      chk("we", {7'h00, mem_we}, {7'h00, r.we});
      if (r.we) chk("wdata", mem_wdata, r.wd);
      chk("skip", {7'h00, skip_taken}, {7'h00, r.sk});
      if (r.sk) begin
        chk("flush", {6'h00, prefetch_flush, busy}, 8'h03);
        req.op = MRSS_OP_SET_BYTE;
        @(negedge core_clk);
        chk("refused", {6'h00, mem_we, busy}, 8'h00);
      end
    end
    // freeze with a write pulse standing: it must neither drop nor repeat
    req.op = MRSS_OP_SET_BYTE;
    @(negedge core_clk);
    chk("set", {mem_wdata[6:0], mem_we}, 8'hFF);
    clk_en = 1'h0;
    req.op = MRSS_OP_SUB_WORK;
    req.mem = 8'h01;
    @(negedge core_clk);
    chk("frozen", {mem_wdata[6:0], mem_we}, 8'hFF);
    chk("frozen work", work, 8'hC3);
    clk_en = 1'h1;
    @(negedge core_clk);
    chk("b2b work", work, 8'hC2);
    chk("b2b flags", {4'h0, flags}, 8'h03);
    // reset in mid-run while the dummy cycle stands
    req.op = MRSS_OP_INC_SKIP;
    req.mem = 8'hFF;
    @(negedge core_clk);
    chk("skip busy", {6'h00, prefetch_flush, busy}, 8'h03);
    req.valid = 1'h0;
    rst_n = 1'h0;
    @(negedge core_clk);
    chk("mid rst out", {5'h00, mem_we, skip_taken, busy}, 8'h00);
    chk("mid rst flush", {7'h00, prefetch_flush}, 8'h00);
    chk("mid rst work", work, 8'h00);
    chk("mid rst flags", {4'h0, flags}, 8'h00);
    // first request right at the edge after release
    rst_n = 1'h1;
    req.valid = 1'h1;
    req.op = MRSS_OP_SUB_WORK;
    req.mem = 8'h01;
    @(negedge core_clk);
    chk("post rst work", work, 8'hFF);
    chk("post rst flags", {4'h0, flags}, 8'h00);
    req.valid = 1'h0;
    wrap_up();
  end
endmodule : testbench
